//--- hw/pot_wiper_serial_updown_ctrl.sv
// Control logic of a 10-bit digital potentiometer: serial or step host port.
// Assumes host pins are asynchronous to ref_clk_i and far slower than it.
`timescale 1ns/1ns
`default_nettype none
module pot_wiper_serial_updown_ctrl
  import pot_pkg::*;
(
  input  wire logic      ref_clk_i,
  input  wire logic      rstn_i,
  input  wire logic      interface_select_i,
  input  wire logic      cs_n_i,
  input  wire logic      data_dir_i,
  input  wire logic      clk_step_i,
  output pot_pkg::wiper_t wiper_o,
  output pot_pkg::wiper_t persistent_position_store_o,
  output logic           store_busy_o
);
  import pot_pkg::*;

  // ==========================================================
  // Pin synchronisation
  logic [3:0] pins_s;
  pin_sync u_sync
  (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .pins_i    ({interface_select_i, cs_n_i, data_dir_i, clk_step_i}),
    .pins_o    (pins_s)
  );
  logic sel_s;
  logic cs_s;
  logic din_s;
  logic sck_s;
  assign sel_s = pins_s[3];
  assign cs_s  = pins_s[2];
  assign din_s = pins_s[1];
  assign sck_s = pins_s[0];

  // ==========================================================
  // Edge detection on synchronised pins
  logic cs_d;
  logic sck_d;
  logic next_cs_d;
  logic next_sck_d;
  always_comb
  begin
    next_cs_d  = cs_s;
    next_sck_d = sck_s;
  end
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cs_d  <= 1'b1;
      sck_d <= 1'b0;
    end
    else
    begin
      cs_d  <= next_cs_d;
      sck_d <= next_sck_d;
    end
  end
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  assign sck_rise = sck_s & ~sck_d;
  assign sck_fall = ~sck_s & sck_d;
  assign cs_rise  = cs_s & ~cs_d;

  // Decides whether a finished frame holds a command we act on
  function automatic logic frame_valid(input logic [`FRAME_CNT_W-1:0] n,
                                       input logic [1:0] c);
    logic ok;
    ok = 1'b0;
    if (c == `CMD_WRITE)
      ok = (n == `EDGE_FRAME_FULL);
    else if (c == `CMD_COPY_STORE || c == `CMD_COPY_WIPER)
      ok = (n == `EDGE_CMD_END) || (n == `EDGE_FRAME_FULL);
    return ok;
  endfunction : frame_valid

  // ==========================================================
  // Serial frame capture
  frame_state_e                state;
  frame_state_e                next_state;
  logic [`FRAME_CNT_W-1:0]     edge_cnt;
  logic [`FRAME_CNT_W-1:0]     next_edge_cnt;
  logic [1:0]                  cmd;
  logic [1:0]                  next_cmd;
  wiper_t                      code;
  wiper_t                      next_code;
  logic                        zero_ok;
  logic                        next_zero_ok;
  logic                        serial_mode;
  assign serial_mode = sel_s;

  // Counts edges while selected; host pins are inputs only
  always_comb
  begin
    next_state    = state;
    next_edge_cnt = edge_cnt;
    next_cmd      = cmd;
    next_code     = code;
    next_zero_ok  = zero_ok;
    case (state)
      ST_IDLE:
      begin
        if (serial_mode && !cs_s)
        begin
          next_state    = ST_SHIFT;
          next_edge_cnt = 5'h00;
          next_zero_ok  = 1'b1;
        end
      end
      ST_SHIFT:
      begin
        if (cs_rise || !serial_mode)
          next_state = ST_DONE;
        else if (sck_rise)
        begin
          if (edge_cnt != `EDGE_FRAME_FULL + 5'h01)
            next_edge_cnt = edge_cnt + 5'h01;
          if (edge_cnt + 5'h01 == `EDGE_CMD_HIGH)
            next_cmd[1] = din_s;
          else if (edge_cnt + 5'h01 == `EDGE_CMD_LOW)
            next_cmd[0] = din_s;
          else if (edge_cnt + 5'h01 >= `EDGE_DATA_FIRST &&
                   edge_cnt + 5'h01 <= `EDGE_DATA_LAST)
            next_code = {code[`WIPER_W-2:0], din_s};
          else if (edge_cnt + 5'h01 <= `EDGE_CMD_END && din_s)
            next_zero_ok = 1'b0; // Nonzero padding marks frame undefined
        end
      end
      ST_DONE:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state    <= ST_IDLE;
      edge_cnt <= 5'h00;
      cmd      <= 2'h0;
      code     <= `WIPER_ZERO;
      zero_ok  <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      edge_cnt <= next_edge_cnt;
      cmd      <= next_cmd;
      code     <= next_code;
      zero_ok  <= next_zero_ok;
    end
  end

  logic frame_go;
  // Mode change mid-frame aborts without executing
  assign frame_go = (state == ST_DONE) && serial_mode && zero_ok &&
                    frame_valid(edge_cnt, cmd);

  // ==========================================================
  // Wiper, store and store timer
  wiper_t                  wiper;
  wiper_t                  next_wiper;
  wiper_t                  store;
  wiper_t                  next_store;
  logic [`STORE_CNT_W-1:0] busy_cnt;
  logic [`STORE_CNT_W-1:0] next_busy_cnt;
  wiper_t                  store_pending;
  wiper_t                  next_store_pending;
  logic                    loaded;
  logic                    next_loaded;
  logic                    step_mode;
  assign step_mode = ~sel_s;

  // Store commits at end of the write period, modelling cell latency
  always_comb
  begin
    next_wiper         = wiper;
    next_store         = store;
    next_busy_cnt      = busy_cnt;
    next_store_pending = store_pending;
    next_loaded        = 1'b1;
    if (!loaded)
      next_wiper = store;
    else if (frame_go && cmd == `CMD_WRITE)
      next_wiper = code;
    else if (frame_go && cmd == `CMD_COPY_WIPER)
      next_wiper = store;
    else if (step_mode && !cs_s && sck_fall)
    begin
      if (din_s && wiper != `WIPER_MAX)
        next_wiper = wiper + 10'h001;
      else if (!din_s && wiper != `WIPER_ZERO)
        next_wiper = wiper - 10'h001;
    end
    if (busy_cnt != '0)
    begin
      next_busy_cnt = busy_cnt - 20'h0_0001;
      if (busy_cnt == 20'h0_0001)
        next_store = store_pending;
    end
    else if ((frame_go && cmd == `CMD_COPY_STORE) ||
             (step_mode && cs_rise && sck_s))
    begin
      next_store_pending = wiper;
      next_busy_cnt      = `STORE_CNT_W'(`STORE_CYCLES);
    end
  end
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wiper         <= `WIPER_ZERO;
      store         <= `STORE_RESET;
      busy_cnt      <= '0;
      store_pending <= `WIPER_ZERO;
      loaded        <= 1'b0;
    end
    else
    begin
      wiper         <= next_wiper;
      store         <= next_store;
      busy_cnt      <= next_busy_cnt;
      store_pending <= next_store_pending;
      loaded        <= next_loaded;
    end
  end

  assign wiper_o                     = wiper;
  assign persistent_position_store_o = store;
  assign store_busy_o                = (busy_cnt != '0);
endmodule : pot_wiper_serial_updown_ctrl
`default_nettype wire

//--- hw/pot_cfg.svh
// Constants for the wiper control block: frame layout, codes and timing.
// Assumes inclusion by the package and pin_sync by bare name.
`ifndef POT_CFG_SVH
`define POT_CFG_SVH
`define WIPER_W         10
`define PIN_IDLE        4'h4
`define WIPER_MAX       10'h3ff
`define WIPER_ZERO      10'h000
`define STORE_RESET     10'h200
`define FRAME_CNT_W     5
`define EDGE_CMD_HIGH   5'h03
`define EDGE_CMD_LOW    5'h04
`define EDGE_CMD_END    5'h08
`define EDGE_DATA_FIRST 5'h09
`define EDGE_DATA_LAST  5'h12
`define EDGE_FRAME_FULL 5'h18
`define CMD_WRITE       2'h0
`define CMD_COPY_STORE  2'h2
`define CMD_COPY_WIPER  2'h3
`define CLK_MHZ         25
`define STORE_TIME_MS   12
`define STORE_CYCLES    (`STORE_TIME_MS * `CLK_MHZ * 1000)
`define STORE_CNT_W     20
`endif

//--- hw/pot_pkg.sv
// Types shared by the wiper control block.
// Assumes pot_cfg.svh is on the include path.
`include "pot_cfg.svh"
package pot_pkg;
  typedef logic [`WIPER_W-1:0] wiper_t;
  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE  = 2'b11
  } frame_state_e;
endpackage : pot_pkg

//--- hw/pin_sync.sv
// Two-flop synchroniser bank for the host pins.
// Assumes asynchronous active-low reset; pins idle low except chip select.
`timescale 1ns/1ns
`default_nettype none
`include "pot_cfg.svh"
module pin_sync
(
  input  wire logic       ref_clk_i,
  input  wire logic       rstn_i,
  input  wire logic [3:0] pins_i,
  output logic      [3:0] pins_o
);
  logic [3:0] stage1;
  logic [3:0] stage2;
  // ==========================================================
  // Two stages; only the second is ever read
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      // Idle pin levels, so release of reset shows no false select edge
      stage1 <= `PIN_IDLE;
      stage2 <= `PIN_IDLE;
    end
    else
    begin
      stage1 <= pins_i;
      stage2 <= stage1;
    end
  end
  assign pins_o = stage2;
endmodule : pin_sync
`default_nettype wire

//--- bench/pot_chk.sv
// Port checker for the wiper control block.
// Assumes a bind onto the top module and one reference clock domain.
`timescale 1ns/1ns
`default_nettype none
`include "pot_cfg.svh"
module pot_chk
  import pot_pkg::*;
(
  input wire logic            ref_clk_i,
  input wire logic            rstn_i,
  input wire logic            interface_select_i,
  input wire logic            cs_n_i,
  input wire pot_pkg::wiper_t wiper_o,
  input wire pot_pkg::wiper_t persistent_position_store_o,
  input wire logic            store_busy_o
);
  // ======
  // Helpers: age since reset, cycles with select unchanged, cycles deselected
  logic [1:0] age;
  logic [1:0] next_age;
  logic [3:0] sel_cnt;
  logic [3:0] next_sel;
  logic [3:0] hi_cnt;
  logic [3:0] next_hi;
  logic       sel_q;
  always_comb
  begin
    next_age = (age == 2'h3) ? age : age + 2'h1;
    next_sel = (interface_select_i != sel_q) ? 4'h0 : sel_cnt + {3'h0, sel_cnt != 4'hf};
    next_hi  = cs_n_i ? hi_cnt + {3'h0, hi_cnt != 4'hf} : 4'h0;
  end
  // Cleared by reset so that recall is never mistaken for a move
  always_ff @(posedge ref_clk_i or negedge rstn_i)
    if (!rstn_i)
      {age, sel_cnt, hi_cnt, sel_q} <= '0;
    else
      {age, sel_cnt, hi_cnt, sel_q} <= {next_age, next_sel, next_hi, interface_select_i};
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  AST_STORE_HOLD: assert property (!store_busy_o && !$past(store_busy_o)
    |-> $stable(persistent_position_store_o)) else $error("store moved while idle");
  AST_BUSY_SPAN: assert property ($rose(store_busy_o) |=> store_busy_o[*8])
    else $error("store write too short");
  AST_CS_IDLE: assert property (hi_cnt == 4'hf && $past(hi_cnt) == 4'hf
    |-> $stable(wiper_o)) else $error("wiper moved while deselected");
  AST_STEP_ONE: assert property ($changed(wiper_o) && !interface_select_i
    && sel_cnt == 4'hf |-> wiper_o == $past(wiper_o) + 1 || wiper_o == $past(wiper_o) - 1)
    else $error("step not one code");
  AST_BUSY_CAUSE: assert property ($rose(store_busy_o)
    |-> $past(cs_n_i) && $past(cs_n_i, 2)) else $error("store without select rise");
  AST_RESET_STORE: assert property (age == 2'h1
    |-> persistent_position_store_o == `STORE_RESET && !store_busy_o) else $error("bad reset");
  AST_RECALL: assert property (age == 2'h1 |-> wiper_o == persistent_position_store_o)
    else $error("no power-up recall");
  AST_SERIAL_AT_CS: assert property ($changed(wiper_o) && interface_select_i
    && sel_cnt == 4'hf |-> cs_n_i) else $error("serial move inside frame");
  cover property ($rose(store_busy_o));
  cover property ($changed(wiper_o) && !interface_select_i);
  cover property ($changed(wiper_o) && interface_select_i);
endmodule : pot_chk
`default_nettype wire

//--- bench/pot_host.sv
// Host model driving the serial or step pins of the wiper block.
// Assumes the bench calls its tasks; pins change on ref_clk_i falls.
`timescale 1ns/1ns
`default_nettype none
module pot_host
(
  input  wire logic ref_clk_i,
  output logic      interface_select_o,
  output logic      cs_n_o,
  output logic      data_dir_o,
  output logic      clk_step_o
);
  // ======
  // Half of the 320 ns link period, in reference clocks
  localparam int HALF = 4;
  initial {interface_select_o, cs_n_o, data_dir_o, clk_step_o} = 4'h4;
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : tick
  // Frame of n bits, first bit on edge one; link clock idles low
  task automatic frame(input logic [23:0] bits, input int n);
    tick(1);
    interface_select_o = 1'b1;
    tick(HALF);
    cs_n_o = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      data_dir_o = bits[23-i];
      tick(HALF);
      clk_step_o = 1'b1;
      tick(HALF);
      clk_step_o = 1'b0;
    end
    tick(HALF);
    cs_n_o = 1'b1;
    data_dir_o = ~data_dir_o; // Released line must not keep a stale level
    tick(HALF);
  endtask : frame
  // n falling steps toward dir, then deselect with the step pin at lvl
  task automatic steps(input logic dir, input int n, input logic lvl, input logic cs);
    tick(1);
    interface_select_o = 1'b0;
    clk_step_o = 1'b1;
    data_dir_o = dir;
    tick(HALF);
    cs_n_o = cs;
    tick(HALF);
    for (int k = 0; k < n; k++)
    begin
      clk_step_o = 1'b0;
      tick(HALF);
      if (k < n - 1 || lvl)
        clk_step_o = 1'b1; // Ending low must not add one more step fall
      tick(HALF);
    end
    tick(HALF);
    cs_n_o = 1'b1;
    tick(HALF);
    clk_step_o = 1'b0;
  endtask : steps
endmodule : pot_host
`default_nettype wire

//--- bench/test_pot_wiper_serial_updown_ctrl.sv
// Self-checking bench for the wiper block against an integer model.
// Assumes the design, pot_host and pot_chk are compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_pot_wiper_serial_updown_ctrl
  import pot_pkg::*;
;
  logic   ref_clk_i;
  logic   rstn_i;
  logic   sel;
  logic   cs_n;
  logic   dd;
  logic   stp;
  logic   busy;
  wiper_t wiper;
  wiper_t store;
  int     error_cnt;
  int     samples_checked;
  int     wip;
  int     sto;
  pot_host u_host (.ref_clk_i(ref_clk_i), .interface_select_o(sel), .cs_n_o(cs_n),
    .data_dir_o(dd), .clk_step_o(stp));
  pot_wiper_serial_updown_ctrl u_dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .interface_select_i(sel), .cs_n_i(cs_n), .data_dir_i(dd), .clk_step_i(stp),
    .wiper_o(wiper), .persistent_position_store_o(store), .store_busy_o(busy));
  // ======
  initial
  begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  task automatic cmp(input wiper_t got, input int exp);
    samples_checked++;
    if (got !== wiper_t'(exp))
    begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  // Fixed wait covers the synchroniser and decode latency
  task automatic settle;
    repeat (12) @(negedge ref_clk_i);
    cmp(wiper, wip);
    cmp(store, sto);
  endtask : settle
  task automatic reset_dut;
    @(negedge ref_clk_i);
    rstn_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    rstn_i = 1'b1;
    wip = 512;
    sto = 512;
  endtask : reset_dut
  task automatic stop_test;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  initial
  begin
    #400000;
    error_cnt++;
    stop_test();
  end
  initial
  begin
    int         c;
    wiper_t     v;
    logic [7:0] bad [3];
    bad = '{8'h10, 8'h81, 8'h40};
    rstn_i = 1'b0;
    error_cnt = 0;
    samples_checked = 0;
    c = $urandom(32'h35ad);
    reset_dut();
    settle();
    for (int i = 0; i < 4; i++)
    begin
      v = (i == 0) ? 10'h000 : (i == 1) ? 10'h3ff : wiper_t'($urandom);
      u_host.frame({8'h00, v, 6'($urandom)}, 24);
      wip = v;
      settle();
    end
    foreach (bad[i])
    begin
      v = ~wiper_t'(wip);
      u_host.frame({bad[i], v, 6'h00}, 24);
      settle();
    end
    for (int n = 8; n <= 24; n += 16)
    begin
      u_host.frame({8'h00, 10'h155, 6'h00}, 24);
      u_host.frame({8'h30, 16'($urandom)}, n);
      wip = sto;
      settle();
    end
    for (int i = 0; i < 2; i++)
    begin
      v = i ? 10'h002 : 10'h3fd;
      u_host.frame({8'h00, v, 6'h00}, 24);
      u_host.steps(!i, 4, 1'b0, 1'b0);
      wip = i ? 0 : 1023;
      settle();
    end
    u_host.steps(1'b1, 3, 1'b0, 1'b1);
    settle();
    c = 1 + $urandom % 6;
    u_host.steps(1'b1, c, 1'b0, 1'b0);
    wip += c;
    settle();
    cmp(wiper_t'(busy), 0);
    u_host.steps(1'b0, 1, 1'b1, 1'b0);
    wip -= 1;
    settle();
    cmp(wiper_t'(busy), 1);
    reset_dut();
    settle();
    u_host.frame({8'h20, 16'h0000}, 24);
    settle();
    cmp(wiper_t'(busy), 1);
    stop_test();
  end
endmodule : test_pot_wiper_serial_updown_ctrl
bind pot_wiper_serial_updown_ctrl pot_chk u_chk (.ref_clk_i, .rstn_i, .interface_select_i,
  .cs_n_i, .wiper_o, .persistent_position_store_o, .store_busy_o);
`default_nettype wire
